// >>> rtl/tbi_cmd_port.sv
// Overview of operation
// - Command 0x08 written to offset 0xA0 puts the device into setup mode.
// - Command 0x07 written to offset 0xA0 returns the device to normal sensing.
// - Command 0x02 at 0xA0 reloads working configuration with defaults, leaving storage alone.
// - Command 0x01 at 0xA0 saves the configuration, and the host waits out the save time.
// - Command 0x06 at 0xA0 soft-resets the device, and the host enters setup mode first.
// - Writing 0x01 to offset 0x06 in setup mode enables the first sense pin as a button.
// - A one-hot mask written to offset 0x81 picks the button whose scan results are read.
// - Six reads from pointer 0x82 give baseline, difference and raw count, two bytes each.
// - One read from pointer 0x88 gives the touched status of the buttons.
// - The first written byte of a transfer sets the pointer and reads start at the pointer.
`timescale 1ns/100ps
`default_nettype none

module tbi_cmd_port
	import tbi_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h00
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire tbi_scan_t scan_in,
	input wire logic [7:0] button_status,
	output tbi_ctrl_t ctrl
);

	// ************************************************************
	// Parameter check
	// ************************************************************
	if (DEV_ADDR > 7'h77) begin : g_bad_addr
		$error("Target address lies in the reserved upper range.");
	end

	tbi_state_t st_r;
	tbi_state_t st_nxt;

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic scl_now;
	logic sda_now;

	// Scan data reads come from the snapshot so the six scan bytes belong to one scan.
	function automatic logic [7:0] read_mux(input logic [7:0] ofs, input tbi_ctrl_t c,
		input logic [47:0] snap, input logic [7:0] status);
		logic [2:0] idx;
		idx = 3'(ofs - TBI_OFS_SCAN_DATA);
		if (ofs == TBI_OFS_BTN_EN) begin
			read_mux = c.button_enable;
		end else if (ofs == TBI_OFS_SCAN_SEL) begin
			read_mux = c.scan_select;
		end else if (ofs >= TBI_OFS_SCAN_DATA && ofs <= TBI_OFS_SCAN_LAST) begin
			read_mux = snap[47 - 8 * idx -: 8];
		end else if (ofs == TBI_OFS_BTN_STATUS) begin
			read_mux = status;
		end else begin
			read_mux = TBI_UNMAPPED_READ;
		end
	endfunction

	// ************************************************************
	// Bus condition detection
	// ************************************************************
	// Only stages 1 and 2 of each synchroniser feed logic; stage 0 is metastability guard.
	assign scl_now = st_r.scl_sync[1];
	assign sda_now = st_r.sda_sync[1];
	assign scl_rise = st_r.scl_sync[1] && !st_r.scl_sync[2];
	assign scl_fall = !st_r.scl_sync[1] && st_r.scl_sync[2];
	assign bus_start = scl_now && st_r.scl_sync[2] && !sda_now && st_r.sda_sync[2];
	assign bus_stop = scl_now && st_r.scl_sync[2] && sda_now && !st_r.sda_sync[2];

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.scl_sync = {st_r.scl_sync[1:0], scl_in};
		st_nxt.sda_sync = {st_r.sda_sync[1:0], sda_in};
		st_nxt.ctrl.load_defaults = 1'b0;
		st_nxt.ctrl.save_nv = 1'b0;
		st_nxt.ctrl.soft_reset = 1'b0;

		if (bus_start) begin
			st_nxt.phase = TBI_ADDR;
			st_nxt.bit_cnt = 4'h0;
			st_nxt.sda_drive_low = 1'b0;
		end else if (bus_stop) begin
			st_nxt.phase = TBI_IDLE;
			st_nxt.sda_drive_low = 1'b0;
		end else begin
			case (st_r.phase)
				TBI_IDLE: begin
					st_nxt.sda_drive_low = 1'b0;
				end
				TBI_ADDR, TBI_WRITE: begin
					if (scl_rise && st_r.bit_cnt != TBI_BITS_PER_BYTE) begin
						st_nxt.shift = {st_r.shift[6:0], sda_now};
						st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
					end else if (scl_fall && st_r.bit_cnt == TBI_BITS_PER_BYTE) begin
						if (st_r.phase == TBI_ADDR) begin
							if (st_r.shift[7:1] == DEV_ADDR) begin
								st_nxt.is_read = st_r.shift[0];
								st_nxt.first_byte = 1'b1;
								st_nxt.sda_drive_low = 1'b1;
								st_nxt.phase = TBI_ACK;
							end else begin
								// Another target's transfer: stay off the bus until the next start.
								st_nxt.phase = TBI_IDLE;
							end
						end else begin
							st_nxt.sda_drive_low = 1'b1;
							st_nxt.phase = TBI_ACK;
							st_nxt.first_byte = 1'b0;
							if (st_r.first_byte) begin
								st_nxt.reg_ptr = st_r.shift;
							end else begin
								st_nxt.reg_ptr = st_r.reg_ptr + 8'h01;
								case (st_r.reg_ptr)
									TBI_OFS_BTN_EN: begin
										// Outside setup mode only command 0x02 can change the button map.
										if (st_r.ctrl.setup_mode) begin
											st_nxt.ctrl.button_enable = st_r.shift;
										end
									end
									TBI_OFS_SCAN_SEL: begin
										st_nxt.ctrl.scan_select = st_r.shift;
									end
									TBI_OFS_COMMAND: begin
										case (st_r.shift)
											TBI_CMD_SETUP: begin
												st_nxt.ctrl.setup_mode = 1'b1;
											end
											TBI_CMD_NORMAL: begin
												st_nxt.ctrl.setup_mode = 1'b0;
											end
											TBI_CMD_LOAD_DEF: begin
												st_nxt.ctrl.load_defaults = 1'b1;
												st_nxt.ctrl.button_enable = TBI_RST_BTN_EN;
												st_nxt.ctrl.scan_select = TBI_RST_SCAN_SEL;
											end
											TBI_CMD_SAVE_NV: begin
												st_nxt.ctrl.save_nv = 1'b1;
											end
											TBI_CMD_SOFT_RST: begin
												// Ignored in normal mode so a stray write cannot reset sensing.
												if (st_r.ctrl.setup_mode) begin
													st_nxt.ctrl.soft_reset = 1'b1;
													st_nxt.ctrl.setup_mode = 1'b0;
													st_nxt.ctrl.button_enable = TBI_RST_BTN_EN;
													st_nxt.ctrl.scan_select = TBI_RST_SCAN_SEL;
												end
											end
											default: begin
											end
										endcase
									end
									default: begin
									end
								endcase
							end
						end
					end
				end
				TBI_ACK: begin
					if (scl_fall) begin
						st_nxt.bit_cnt = 4'h0;
						if (st_r.is_read) begin
							st_nxt.shift = read_mux(st_r.reg_ptr, st_r.ctrl, st_r.scan_snap,
								button_status);
							st_nxt.sda_drive_low = !st_nxt.shift[7];
							st_nxt.phase = TBI_READ;
						end else begin
							st_nxt.sda_drive_low = 1'b0;
							st_nxt.phase = TBI_WRITE;
						end
					end
				end
				TBI_READ: begin
					if (scl_rise) begin
						st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (st_r.bit_cnt == TBI_BITS_PER_BYTE) begin
							st_nxt.sda_drive_low = 1'b0;
							st_nxt.reg_ptr = st_r.reg_ptr + 8'h01;
							st_nxt.phase = TBI_RACK;
						end else begin
							st_nxt.shift = {st_r.shift[6:0], 1'b0};
							st_nxt.sda_drive_low = !st_r.shift[6];
						end
					end
				end
				TBI_RACK: begin
					if (scl_rise) begin
						st_nxt.master_nack = sda_now;
					end else if (scl_fall) begin
						if (st_r.master_nack) begin
							st_nxt.phase = TBI_IDLE;
						end else begin
							st_nxt.bit_cnt = 4'h0;
							st_nxt.shift = read_mux(st_r.reg_ptr, st_r.ctrl, st_r.scan_snap,
								button_status);
							st_nxt.sda_drive_low = !st_nxt.shift[7];
							st_nxt.phase = TBI_READ;
						end
					end
				end
				default: begin
					st_nxt.phase = TBI_IDLE;
					st_nxt.sda_drive_low = 1'b0;
				end
			endcase
		end

		// Capture all six scan bytes whenever the pointer sits at the first one and the port is not in the read phase.
		if (st_nxt.reg_ptr == TBI_OFS_SCAN_DATA && st_nxt.phase != TBI_READ) begin
			st_nxt.scan_snap = scan_in;
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '{scl_sync: 3'h7, sda_sync: 3'h7, phase: TBI_IDLE, bit_cnt: 4'h0,
				shift: 8'h00, is_read: 1'b0, first_byte: 1'b0, master_nack: 1'b0,
				reg_ptr: TBI_RST_PTR, scan_snap: 48'h0, sda_drive_low: 1'b0,
				ctrl: '{setup_mode: 1'b0, button_enable: TBI_RST_BTN_EN,
					scan_select: TBI_RST_SCAN_SEL, load_defaults: 1'b0, save_nv: 1'b0,
					soft_reset: 1'b0}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Open-drain data line: the device only ever pulls low.
	assign sda_out = 1'b0;
	assign sda_oe = st_r.sda_drive_low;
	assign ctrl = st_r.ctrl;

endmodule

`default_nettype wire

// >>> rtl/tbi_pkg.sv
`default_nettype none
package tbi_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] TBI_OFS_BTN_EN = 8'h06;
	localparam logic [7:0] TBI_OFS_SCAN_SEL = 8'h81;
	localparam logic [7:0] TBI_OFS_SCAN_DATA = 8'h82;
	localparam logic [7:0] TBI_OFS_SCAN_LAST = 8'h87;
	localparam logic [7:0] TBI_OFS_BTN_STATUS = 8'h88;
	localparam logic [7:0] TBI_OFS_COMMAND = 8'hA0;

	// ************************************************************
	// Command codes
	// ************************************************************
	localparam logic [7:0] TBI_CMD_SAVE_NV = 8'h01;
	localparam logic [7:0] TBI_CMD_LOAD_DEF = 8'h02;
	localparam logic [7:0] TBI_CMD_SOFT_RST = 8'h06;
	localparam logic [7:0] TBI_CMD_NORMAL = 8'h07;
	localparam logic [7:0] TBI_CMD_SETUP = 8'h08;

	// ************************************************************
	// Reset values and bus constants
	// ************************************************************
	localparam logic [7:0] TBI_RST_BTN_EN = 8'h00;
	localparam logic [7:0] TBI_RST_SCAN_SEL = 8'h01;
	localparam logic [7:0] TBI_RST_PTR = 8'h00;
	localparam logic [7:0] TBI_UNMAPPED_READ = 8'h00;
	localparam logic [3:0] TBI_BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		TBI_IDLE,
		TBI_ADDR,
		TBI_WRITE,
		TBI_ACK,
		TBI_READ,
		TBI_RACK
	} tbi_phase_t;

	// Scan results of the selected button, delivered by the sensing core.
	typedef struct packed {
		logic [15:0] baseline;
		logic [15:0] diff_count;
		logic [15:0] raw_count;
	} tbi_scan_t;

	// Configuration and event outputs toward the sensing core.
	typedef struct packed {
		logic setup_mode;
		logic [7:0] button_enable;
		logic [7:0] scan_select;
		logic load_defaults;
		logic save_nv;
		logic soft_reset;
	} tbi_ctrl_t;

	typedef struct packed {
		logic [2:0] scl_sync;
		logic [2:0] sda_sync;
		tbi_phase_t phase;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic is_read;
		logic first_byte;
		logic master_nack;
		logic [7:0] reg_ptr;
		logic [47:0] scan_snap;
		logic sda_drive_low;
		tbi_ctrl_t ctrl;
	} tbi_state_t;

endpackage
`default_nettype wire

// >>> test/tbi_cmd_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tbi_cmd_port_checker
	import tbi_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire tbi_scan_t scan_in,
	input wire logic [7:0] button_status,
	input wire tbi_ctrl_t ctrl
);
	// ********
	// Mode and control changes
	// ********
	// Every change of mode or configuration is tied to the acknowledge that completes a byte.
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_setup_on_ack: assert property ($rose(ctrl.setup_mode) |-> sda_oe)
		else $error("setup entry outside ack");
	chk_normal_on_ack: assert property ($fell(ctrl.setup_mode) |-> sda_oe)
		else $error("setup exit outside ack");
	chk_load_pulse: assert property (ctrl.load_defaults |-> sda_oe ##1 !ctrl.load_defaults)
		else $error("load pulse wrong");
	chk_save_pulse: assert property (ctrl.save_nv |-> sda_oe ##1 !ctrl.save_nv)
		else $error("save pulse wrong");
	chk_reset_setup: assert property (ctrl.soft_reset |-> $past(ctrl.setup_mode))
		else $error("soft reset outside setup");
	chk_enable_setup: assert property (
		$changed(ctrl.button_enable) && ctrl.button_enable != TBI_RST_BTN_EN |-> $past(ctrl.setup_mode))
		else $error("enable written outside setup");
	chk_select_on_ack: assert property ($changed(ctrl.scan_select) |-> sda_oe)
		else $error("select changed outside ack");
	chk_oe_scl_high: assert property (scl_in [*6] |-> $stable(sda_oe))
		else $error("sda changed while scl high");
	cover property (ctrl.save_nv);
	cover property (ctrl.soft_reset);
	cover property ($rose(ctrl.button_enable[0]));
endmodule
bind tbi_cmd_port tbi_cmd_port_checker i_tbi_cmd_port_checker (.core_clk(core_clk), .rst_b(rst_b),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .scan_in(scan_in),
	.button_status(button_status), .ctrl(ctrl));
`default_nettype wire

// >>> test/tbi_cmd_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module tbi_cmd_port_test;
	import tbi_pkg::*;
	localparam logic [6:0] ADDR = 7'h00;
	// Host pause after a save command; the value is a plain stand-in for the save time.
	localparam int SAVE_WAIT = 200;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic scl;
	logic host_low;
	logic sda_oe;
	logic sda_out;
	tbi_scan_t scan_in = '0;
	logic [7:0] button_status = 8'h00;
	tbi_ctrl_t ctrl;
	int err_total = 0;
	int n_compared = 0;
	int pulses[3] = '{0, 0, 0};
	logic ok;
	logic [7:0] q[$];
	wire logic sda_line = (sda_oe ? sda_out : 1'b1) && !host_low;
	tbi_cmd_port #(.DEV_ADDR(ADDR)) i_tbi_cmd_port (.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .scan_in(scan_in),
		.button_status(button_status), .ctrl(ctrl));
	tbi_host_model i_tbi_host_model (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
		.sda_low(host_low));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		pulses[0] += int'(ctrl.load_defaults);
		pulses[1] += int'(ctrl.save_nv);
		pulses[2] += int'(ctrl.soft_reset);
	end
	// ********
	// Checking and bus tasks
	// ********
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	function automatic logic [7:0] exp_scan(input tbi_scan_t s, input int i);
		return s[47 - 8 * i -: 8];
	endfunction
	task automatic wr(input logic [6:0] a, input logic [7:0] b[$], output logic all_ack);
		logic [7:0] rx;
		logic nack;
		i_tbi_host_model.start();
		i_tbi_host_model.xfer_byte({a, 1'b0}, 1'b1, rx, nack);
		all_ack = !nack;
		foreach (b[i]) begin
			i_tbi_host_model.xfer_byte(b[i], 1'b1, rx, nack);
			all_ack &= !nack;
		end
		i_tbi_host_model.stop();
	endtask
	task automatic rd(input int n, output logic [7:0] got[$]);
		logic [7:0] rx;
		logic nack;
		got = {};
		i_tbi_host_model.start();
		i_tbi_host_model.xfer_byte({ADDR, 1'b1}, 1'b1, rx, nack);
		check(nack, 1'b0);
		for (int i = 0; i < n; i++) begin
			i_tbi_host_model.xfer_byte(8'hFF, i == n - 1, rx, nack);
			got.push_back(rx);
		end
		i_tbi_host_model.stop();
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(ADDR, {TBI_OFS_COMMAND, c}, ok);
		check(ok, 1'b1);
	endtask
	initial begin
		repeat (100000) @(posedge core_clk);
		err_total++;
		finish_test();
	end
	initial begin
		void'($urandom(23));
		repeat (12) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		check(ctrl, {1'b0, TBI_RST_BTN_EN, TBI_RST_SCAN_SEL, 3'h0});
		wr(ADDR, {TBI_OFS_BTN_EN, 8'h01}, ok);
		cmd(TBI_CMD_SOFT_RST);
		check(ctrl.button_enable, TBI_RST_BTN_EN);
		check(pulses[2], 0);
		wr(ADDR + 7'h01, {TBI_OFS_COMMAND, TBI_CMD_SETUP}, ok);
		check({ok, ctrl.setup_mode}, 2'h0);
		cmd(TBI_CMD_SETUP);
		check(ctrl.setup_mode, 1'b1);
		cmd(TBI_CMD_NORMAL);
		check(ctrl.setup_mode, 1'b0);
		cmd(TBI_CMD_SETUP);
		wr(ADDR, {8'h05, 8'h5A, 8'h01}, ok);
		check(ctrl.button_enable, 8'h01);
		wr(ADDR, {8'h80, 8'hC3, 8'h02}, ok);
		check(ctrl.scan_select, 8'h02);
		wr(ADDR, {8'h05}, ok);
		rd(2, q);
		check({q[0], q[1]}, {TBI_UNMAPPED_READ, 8'h01});
		cmd(TBI_CMD_SAVE_NV);
		check(pulses[1], 1);
		i_tbi_host_model.tick(SAVE_WAIT);
		cmd(TBI_CMD_LOAD_DEF);
		check(pulses[0], 1);
		check({ctrl.button_enable, ctrl.scan_select}, {TBI_RST_BTN_EN, TBI_RST_SCAN_SEL});
		cmd(8'h55);
		check(pulses[0] + pulses[1] + pulses[2], 2);
		wr(ADDR, {TBI_OFS_SCAN_SEL, 8'h01}, ok);
		check(ctrl.scan_select, 8'h01);
		repeat (3) begin
			scan_in <= 48'({$urandom, $urandom});
			button_status <= 8'($urandom);
			wr(ADDR, {TBI_OFS_SCAN_DATA}, ok);
			rd(6, q);
			foreach (q[i]) check(q[i], exp_scan(scan_in, i));
			// The pointer has run on to the status byte, so no new pointer write is needed.
			rd(1, q);
			check(q[0], button_status);
		end
		cmd(TBI_CMD_SOFT_RST);
		check({ctrl.setup_mode, ctrl.soft_reset}, 2'h0);
		check(pulses[2], 1);
		finish_test();
	end
endmodule
`default_nettype wire

// >>> test/tbi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// The host only pulls SDA low or lets the pull-up take it, so a released bit reads the device.
module tbi_host_model (
	input wire logic core_clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic start();
		sda_low <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(6);
		sda_low <= 1'b1;
		tick(6);
		scl <= 1'b0;
		tick(4);
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(6);
		sda_low <= 1'b0;
		tick(8);
	endtask
	task automatic xfer_byte(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx,
		output logic ack_in);
		logic [8:0] io;
		io = {tx, ack_out};
		for (int i = 8; i >= 0; i--) begin
			sda_low <= !io[i];
			tick(4);
			scl <= 1'b1;
			tick(4);
			io[i] = sda_line;
			tick(4);
			scl <= 1'b0;
			tick(4);
		end
		rx = io[8:1];
		ack_in = io[0];
	endtask
endmodule
`default_nettype wire
